// >>> rtl/tmp_ctrl.sv
// tmp_ctrl: poll command, status read selection and trigger mode banks for
// the cascaded pair of interrupt controllers.
// assumes a host i/o port with one-cycle read and write strobes on clk.
// Overview of operation
// - poll bit makes next read an acknowledge
// - bit 1 clear keeps read selection
// - codes 10/11 select pending or in-service
// - initialization resets selection to pending register
// - selection persists across reads until rewritten
// - low bank bits 3-7 pick level, reset 00h
// - irq0, irq1, irq2 always edge
// - level line pending while pin high
// - high bank maps irq9-12,14,15, reset 00h
// - irq8 and irq13 always edge
// - operation word three needs bits 4:3 = 01
// - special masking needs enable and select set
`timescale 1ns/100ps
module tmp_ctrl #(
	parameter int LINES = 8
) (
	input wire logic clk, // system clock
	input wire logic rst, // synchronous reset, active high
	input wire logic [15:0] io_addr, // port address
	input wire logic io_wr, // one-cycle write strobe
	input wire logic io_rd, // one-cycle read strobe
	input wire logic [7:0] io_wdata, // write data
	input wire logic [15:0] irq_pin, // request pins irq15..irq0
	output logic [7:0] io_rdata, // read data, registered
	output logic io_rvalid, // read data valid pulse
	output logic special_mask_mst, // master in special masking
	output logic special_mask_slv // slave in special masking
);
	tmp_req_if #(.WIDTH(LINES)) req_mst ();
	tmp_req_if #(.WIDTH(LINES)) req_slv ();

	logic [7:0] trig_lo_ff, trig_hi_ff, nxt_trig_lo, nxt_trig_hi;
	// per controller state; index 0 is the master, index 1 the slave
	logic [1:0] rsel_ff; // 0 reads pending, 1 reads in-service
	logic [1:0] nxt_rsel;
	logic [1:0] poll_ff; // poll armed for the next command read
	logic [1:0] nxt_poll;
	logic [1:0] msel_ff; // special masking active
	logic [1:0] nxt_msel;
	// in_service_register copies; set only by a poll acknowledge
	logic [LINES-1:0] insvc_mst_ff;
	logic [LINES-1:0] insvc_slv_ff;
	logic [LINES-1:0] nxt_insvc_mst;
	logic [LINES-1:0] nxt_insvc_slv;
	logic [LINES-1:0] ack_mst, ack_slv;
	logic [7:0] rdata_ff, nxt_rdata;
	logic rvalid_ff;
	logic [7:0] poll_mst, poll_slv;
	logic [LINES-1:0] hit_mst, hit_slv;

	// fixed lines are forced to edge whatever is stored
	assign req_mst.level_mode = trig_lo_ff & tmp_pkg::TRIG_LO_MASK;
	assign req_slv.level_mode = trig_hi_ff & tmp_pkg::TRIG_HI_MASK;
	assign req_mst.ack = ack_mst;
	assign req_slv.ack = ack_slv;

	// lowest line number wins; the answer carries a flag and the line code
	function automatic logic [7:0] poll_code(input logic [LINES-1:0] p,
		output logic [LINES-1:0] hit);
		logic [7:0] code;
		code = tmp_pkg::DATA_ZERO;
		hit = '0;
		for (int i = LINES - 1; i >= 0; i--) begin
			if (p[i]) begin
				code = tmp_pkg::POLL_FLAG | 8'(i);
				hit = '0;
				hit[i] = 1'b1;
			end
		end
		return code;
	endfunction

	always_comb begin
		poll_mst = poll_code(req_mst.pending, hit_mst);
		poll_slv = poll_code(req_slv.pending, hit_slv);
	end

	// command port writes and reads; index 0 master, 1 slave
	always_comb begin
		logic [1:0] wsel;
		logic [1:0] rdsel;
		wsel = '0;
		rdsel = '0;
		nxt_trig_lo = trig_lo_ff;
		nxt_trig_hi = trig_hi_ff;
		nxt_rsel = rsel_ff;
		nxt_poll = poll_ff;
		nxt_msel = msel_ff;
		nxt_insvc_mst = insvc_mst_ff;
		nxt_insvc_slv = insvc_slv_ff;
		ack_mst = '0;
		ack_slv = '0;
		nxt_rdata = tmp_pkg::DATA_ZERO;
		wsel[0] = io_wr && io_addr == tmp_pkg::ADDR_CMD_MST;
		wsel[1] = io_wr && io_addr == tmp_pkg::ADDR_CMD_SLV;
		rdsel[0] = io_rd && io_addr == tmp_pkg::ADDR_CMD_MST;
		rdsel[1] = io_rd && io_addr == tmp_pkg::ADDR_CMD_SLV;
		// reserved bits are kept as written; only masked copies drive the logic
		if (io_wr && io_addr == tmp_pkg::ADDR_TRIG_LO) begin
			nxt_trig_lo = io_wdata;
		end
		if (io_wr && io_addr == tmp_pkg::ADDR_TRIG_HI) begin
			nxt_trig_hi = io_wdata;
		end
		for (int c = 0; c < 2; c++) begin
			if (wsel[c] && io_wdata[tmp_pkg::BIT_INIT]) begin
				nxt_rsel[c] = 1'b0;
				nxt_poll[c] = 1'b0;
				nxt_msel[c] = 1'b0;
			end else if (wsel[c] &&
				io_wdata[tmp_pkg::BIT_SEL_HI:tmp_pkg::BIT_SEL_LO] == tmp_pkg::SEL_WORD_THREE) begin
				nxt_poll[c] = io_wdata[tmp_pkg::BIT_POLL];
				if (io_wdata[tmp_pkg::BIT_RR]) begin
					nxt_rsel[c] = io_wdata[tmp_pkg::BIT_RIS];
				end // bit 1 clear leaves the selection alone
				// enable clear leaves the select bit without effect
				if (io_wdata[tmp_pkg::BIT_MASK_EN]) begin
					nxt_msel[c] = io_wdata[tmp_pkg::BIT_MASK_SEL];
				end
			end
		end
		// init clears in-service state since end-of-interrupt lives elsewhere
		if (wsel[0] && io_wdata[tmp_pkg::BIT_INIT]) begin
			nxt_insvc_mst = '0;
		end
		if (wsel[1] && io_wdata[tmp_pkg::BIT_INIT]) begin
			nxt_insvc_slv = '0;
		end
		// reads: a pending poll takes one read, then plain status reads resume
		// a poll read acknowledges: the winning line moves to in-service;
		// a level line stays pending while its pin is high, so software
		// polling a level line sees it again until the source lets go
		// plain status reads never touch the selection or the pending bits
		if (rdsel[0]) begin
			if (poll_ff[0]) begin
				nxt_rdata = poll_mst;
				nxt_poll[0] = 1'b0;
				ack_mst = hit_mst;
				nxt_insvc_mst = insvc_mst_ff | hit_mst;
			end else begin
				nxt_rdata = rsel_ff[0] ? insvc_mst_ff : req_mst.pending;
			end
		end else if (rdsel[1]) begin
			if (poll_ff[1]) begin
				nxt_rdata = poll_slv;
				nxt_poll[1] = 1'b0;
				ack_slv = hit_slv;
				nxt_insvc_slv = insvc_slv_ff | hit_slv;
			end else begin
				nxt_rdata = rsel_ff[1] ? insvc_slv_ff : req_slv.pending;
			end
		end else if (io_rd && io_addr == tmp_pkg::ADDR_TRIG_LO) begin
			nxt_rdata = trig_lo_ff & tmp_pkg::TRIG_LO_MASK;
		end else if (io_rd && io_addr == tmp_pkg::ADDR_TRIG_HI) begin
			nxt_rdata = trig_hi_ff & tmp_pkg::TRIG_HI_MASK;
		end
	end

	// register stage for all control state and the read port
	always_ff @(posedge clk) begin
		if (rst) begin
			trig_lo_ff <= tmp_pkg::TRIG_LO_RST;
			trig_hi_ff <= tmp_pkg::TRIG_HI_RST;
			rsel_ff <= '0;
			poll_ff <= '0;
			msel_ff <= '0;
			insvc_mst_ff <= '0;
			insvc_slv_ff <= '0;
			rdata_ff <= tmp_pkg::DATA_ZERO;
			rvalid_ff <= 1'b0;
		end else begin
			trig_lo_ff <= nxt_trig_lo;
			trig_hi_ff <= nxt_trig_hi;
			rsel_ff <= nxt_rsel;
			poll_ff <= nxt_poll;
			msel_ff <= nxt_msel;
			insvc_mst_ff <= nxt_insvc_mst;
			insvc_slv_ff <= nxt_insvc_slv;
			rdata_ff <= nxt_rdata;
			rvalid_ff <= io_rd;
		end
	end

	assign io_rdata = rdata_ff;
	assign io_rvalid = rvalid_ff;
	// outputs come straight from flip-flops
	assign special_mask_mst = msel_ff[0];
	assign special_mask_slv = msel_ff[1];

	// one latch bank per controller; irq7..0 to the master, irq15..8 to the slave
	// the two banks are independent: no cascade line is modelled here,
	// so a slave request is not reflected on the master's line 2
	tmp_req_bank #(.WIDTH(LINES)) u_bank_mst (
		.clk(clk),
		.rst(rst),
		.irq_pin(irq_pin[7:0]),
		.req(req_mst.bank)
	);

	tmp_req_bank #(.WIDTH(LINES)) u_bank_slv (
		.clk(clk),
		.rst(rst),
		.irq_pin(irq_pin[15:8]),
		.req(req_slv.bank)
	);
endmodule // tmp_ctrl

// >>> rtl/tmp_pkg.sv
// tmp_pkg: port addresses, field positions and reset values for the trigger/poll block.
// assumes a byte-wide i/o port space with 16-bit addresses.
package tmp_pkg;
	localparam logic [15:0] ADDR_CMD_MST = 16'h0020; // master command port
	localparam logic [15:0] ADDR_CMD_SLV = 16'h00A0; // slave command port
	localparam logic [15:0] ADDR_TRIG_LO = 16'h04D0; // trigger_mode_low_bank
	localparam logic [15:0] ADDR_TRIG_HI = 16'h04D1; // trigger_mode_high_bank
	localparam logic [7:0] TRIG_LO_RST = 8'h00;
	localparam logic [7:0] TRIG_HI_RST = 8'h00;
	localparam logic [7:0] TRIG_LO_MASK = 8'hF8; // irq0..2 fixed edge
	localparam logic [7:0] TRIG_HI_MASK = 8'hDE; // irq8 and irq13 fixed edge
	localparam int BIT_INIT = 4; // set: initialization_command_word
	localparam int BIT_SEL_HI = 4; // operation word select field
	localparam int BIT_SEL_LO = 3;
	localparam logic [1:0] SEL_WORD_THREE = 2'h1; // pattern 01 in bits 4:3
	localparam int BIT_MASK_SEL = 6; // special_masking_select
	localparam int BIT_MASK_EN = 5; // special_masking_enable
	localparam int BIT_POLL = 2;
	localparam int BIT_RR = 1; // register read enable
	localparam int BIT_RIS = 0; // 0 pending, 1 in-service
	localparam logic [7:0] POLL_FLAG = 8'h80; // poll answer: request present
	localparam logic [7:0] DATA_ZERO = 8'h00;
endpackage

// >>> rtl/tmp_req_if.sv
// tmp_req_if: request lines between the port logic and one request latch bank.
// assumes a single clock shared by both ends.
`timescale 1ns/100ps
interface tmp_req_if #(
	parameter int WIDTH = 8
);
	logic [WIDTH-1:0] level_mode; // 1 = level triggered
	logic [WIDTH-1:0] ack; // one-cycle clear of pending bits
	logic [WIDTH-1:0] pending; // pending_request_register
	modport ctl (output level_mode, output ack, input pending);
	modport bank (input level_mode, input ack, output pending);
endinterface

// >>> rtl/tmp_req_bank.sv
// tmp_req_bank: synchronises request pins and keeps the pending_request_register.
// assumes pins are asynchronous to clk; level_mode and ack come from clk logic.
`timescale 1ns/100ps
module tmp_req_bank #(
	parameter int WIDTH = 8
) (
	input wire logic clk, // system clock
	input wire logic rst, // synchronous reset, active high
	input wire logic [WIDTH-1:0] irq_pin, // raw request pins
	tmp_req_if.bank req // mode in, pending out
);
	logic [WIDTH-1:0] s1_ff, s2_ff, s3_ff, stable_ff, pend_ff;
	logic [WIDTH-1:0] nxt_stable, nxt_pend;
	logic [WIDTH-1:0] rise;

	// a change counts only once the second and third stages agree
	always_comb begin
		rise = '0;
		nxt_stable = stable_ff;
		nxt_pend = pend_ff;
		for (int i = 0; i < WIDTH; i++) begin
			if (s2_ff[i] == s3_ff[i]) begin
				nxt_stable[i] = s3_ff[i];
				rise[i] = s3_ff[i] & ~stable_ff[i];
			end
			if (req.level_mode[i]) begin
				nxt_pend[i] = nxt_stable[i];
			end else if (rise[i]) begin
				nxt_pend[i] = 1'b1;
			end else if (req.ack[i]) begin
				nxt_pend[i] = 1'b0; // set beats a same-cycle ack
			end
		end
	end

	// register stage; s1 feeds only s2
	always_ff @(posedge clk) begin
		if (rst) begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
			stable_ff <= '0;
			pend_ff <= '0;
		end else begin
			s1_ff <= irq_pin;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			stable_ff <= nxt_stable;
			pend_ff <= nxt_pend;
		end
	end

	assign req.pending = pend_ff;
endmodule // tmp_req_bank

// >>> verification/tmp_irq_src.sv
// tmp_irq_src: request line sources standing in for the peripherals.
// assumes the bench sets the wanted levels; lines move after the clock edge.
`timescale 1ns/100ps
module tmp_irq_src (
	input wire logic clk, // clock
	input wire logic [15:0] want, // wanted line levels
	output logic [15:0] irq_pin = 16'h0000 // request lines
);
	// lag the edge so pins look asynchronous to the sampler
	always @(posedge clk) begin
		irq_pin <= #2 want;
	end
endmodule // tmp_irq_src

// >>> verification/tmp_ctrl_properties.sv
// tmp_ctrl_properties: port-level checks of tmp_ctrl.
// assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module tmp_ctrl_properties (
	input wire logic clk, // clock
	input wire logic rst, // reset
	input wire logic [15:0] io_addr, // address
	input wire logic io_wr, // write strobe
	input wire logic io_rd, // read strobe
	input wire logic [7:0] io_wdata, // write data
	input wire logic [15:0] irq_pin, // request pins
	input wire logic [7:0] io_rdata, // read data
	input wire logic io_rvalid, // read valid
	input wire logic special_mask_mst, // master mask mode
	input wire logic special_mask_slv // slave mask mode
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// word three write on the master port
	wire w3 = io_wr && io_addr == tmp_pkg::ADDR_CMD_MST && io_wdata[4:3] == tmp_pkg::SEL_WORD_THREE;
	wire rlo = io_rd && io_addr == tmp_pkg::ADDR_TRIG_LO;
	wire rhi = io_rd && io_addr == tmp_pkg::ADDR_TRIG_HI;
	rd_answer_a: assert property (io_rd |=> io_rvalid)
		else $error("read not answered");
	idle_quiet_a: assert property (!io_rd |=> !io_rvalid && io_rdata == 8'h00)
		else $error("stray read data");
	lo_resv_a: assert property (rlo |=> io_rdata[2:0] == 3'h0)
		else $error("low bank reserved bits set");
	hi_resv_a: assert property (rhi |=> !io_rdata[5] && !io_rdata[0])
		else $error("high bank reserved bits set");
	lo_store_a: assert property (io_wr && io_addr == tmp_pkg::ADDR_TRIG_LO ##2 rlo |=>
		io_rdata == ($past(io_wdata, 3) & tmp_pkg::TRIG_LO_MASK)) else $error("low bank lost");
	hi_store_a: assert property (io_wr && io_addr == tmp_pkg::ADDR_TRIG_HI ##2 rhi |=>
		io_rdata == ($past(io_wdata, 3) & tmp_pkg::TRIG_HI_MASK)) else $error("high bank lost");
	mask_load_a: assert property (w3 && io_wdata[5] |=> special_mask_mst == $past(io_wdata[6]))
		else $error("special mask not loaded");
	mask_keep_a: assert property (w3 && !io_wdata[5] |=> $stable(special_mask_mst))
		else $error("special mask changed");
	poll_form_a: assert property (w3 && io_wdata[2] ##2 io_rd && io_addr == tmp_pkg::ADDR_CMD_MST
		|=> (io_rdata & 8'h78) == 8'h00) else $error("poll answer malformed");
	cover property (w3 && io_wdata[2] ##2 io_rd);
	cover property (io_rvalid && io_rdata[7]);
	cover property ($rose(special_mask_slv));
endmodule // tmp_ctrl_properties
bind tmp_ctrl tmp_ctrl_properties chk (.clk(clk), .rst(rst), .io_addr(io_addr), .io_wr(io_wr),
	.io_rd(io_rd), .io_wdata(io_wdata), .irq_pin(irq_pin), .io_rdata(io_rdata),
	.io_rvalid(io_rvalid), .special_mask_mst(special_mask_mst), .special_mask_slv(special_mask_slv));

// >>> verification/tb.sv
// tb: self-checking bench for tmp_ctrl.
// assumes tmp_irq_src drives the request pins.
`timescale 1ns/100ps
module tb;
	logic clk = 1'b0, rst = 1'b1, io_wr = 1'b0, io_rd = 1'b0, mst, slv, io_rvalid;
	logic [15:0] io_addr = 16'h0000, want = 16'h0000, irq_pin;
	logic [7:0] io_wdata = 8'h00, io_rdata;
	int err_total = 0, total_checks = 0, cycles = 0;
	tmp_irq_src src (.clk(clk), .want(want), .irq_pin(irq_pin));
	tmp_ctrl #(.LINES(8)) dut (.clk(clk), .rst(rst), .io_addr(io_addr), .io_wr(io_wr),
		.io_rd(io_rd), .io_wdata(io_wdata), .irq_pin(irq_pin), .io_rdata(io_rdata),
		.io_rvalid(io_rvalid), .special_mask_mst(mst), .special_mask_slv(slv));
	// free-running clock
	initial begin
		forever #5 clk = ~clk;
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// one strobe per task, with an idle edge before it so strobes never collide
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		io_addr <= a;
		io_wdata <= d;
		io_wr <= 1'b1;
		@(posedge clk);
		io_wr <= 1'b0;
		#1; // let the write land before anyone samples outputs
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk);
		io_addr <= a;
		io_rd <= 1'b1;
		@(posedge clk);
		io_rd <= 1'b0;
		#1;
		chk({7'h00, io_rvalid}, 8'h01);
		chk(io_rdata, e);
	endtask
	task automatic wm(input logic [7:0] d);
		wr(tmp_pkg::ADDR_CMD_MST, d);
	endtask
	task automatic rm(input logic [7:0] e);
		rd(tmp_pkg::ADDR_CMD_MST, e);
	endtask
	task automatic t_reset();
		rd(tmp_pkg::ADDR_TRIG_LO, 8'h00);
		rd(tmp_pkg::ADDR_TRIG_HI, 8'h00);
		rm(8'h00);
	endtask
	task automatic t_banks();
		wr(tmp_pkg::ADDR_TRIG_LO, 8'hff);
		rd(tmp_pkg::ADDR_TRIG_LO, 8'hf8);
		wr(tmp_pkg::ADDR_TRIG_HI, 8'hff);
		rd(tmp_pkg::ADDR_TRIG_HI, 8'hde);
		wr(tmp_pkg::ADDR_TRIG_HI, 8'h00);
		wr(tmp_pkg::ADDR_TRIG_LO, 8'h08);
		rd(tmp_pkg::ADDR_TRIG_LO, 8'h08);
	endtask
	// irq3 level, irq5 edge; poll, status selection and init
	task automatic t_poll();
		want <= 16'h0028;
		repeat (8) @(posedge clk);
		wm(8'h0a);
		rm(8'h28);
		wm(8'h0c);
		rm(8'h83);
		rm(8'h28);
		wm(8'h0b);
		rm(8'h08);
		wm(8'h09);
		rm(8'h08);
		wm(8'h02);
		rm(8'h08);
		want <= 16'h0020;
		repeat (8) @(posedge clk);
		wm(8'h0c);
		rm(8'h85);
		wm(8'h0a);
		rm(8'h00);
		wm(8'h0c);
		rm(8'h00);
		wm(8'h0b);
		want <= 16'h0028;
		repeat (8) @(posedge clk);
		rm(8'h28);
		wm(8'h10);
		rm(8'h08);
	endtask
	task automatic t_mask();
		wm(8'h68);
		chk({7'h00, mst}, 8'h01);
		wm(8'h48);
		chk({7'h00, mst}, 8'h01);
		wm(8'h28);
		chk({7'h00, mst}, 8'h00);
		wr(tmp_pkg::ADDR_CMD_SLV, 8'h68);
		chk({7'h00, slv}, 8'h01);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// hang guard, well above the hundred or so cycles the run needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			err_total++;
			report_and_stop();
		end
	end
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_banks();
		t_poll();
		t_mask();
		report_and_stop();
	end
endmodule // tb
